// ==== shared/mgl_pkg.sv ====
// Purpose: Shared constants and types for the memory-management glue block
// Assumes: 20 MHz system clock; all bus strobes sampled synchronously
// Notes: Hold and search figures are plain defaults, not measured values
package mgl_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int MGL_UPA_W = 24; // Upper physical address, bits 8..31
	localparam int MGL_LOW_W = 8; // Low-order shared address, bits 0..7
	localparam int MGL_IDX_W = 3; // Translation cache index
	localparam int MGL_TAG_W = MGL_UPA_W - MGL_IDX_W;
	localparam int MGL_ENTRIES = 8;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int MGL_CLK_PERIOD_NS = 50;
	localparam int MGL_PA_HOLD_NS = 100; // Least hold of upper address after strobe
	localparam int MGL_PA_HOLD_RAW = (MGL_PA_HOLD_NS + MGL_CLK_PERIOD_NS - 1) / MGL_CLK_PERIOD_NS;
	localparam int MGL_PA_HOLD_CYC = (MGL_PA_HOLD_RAW < 1) ? 1 : MGL_PA_HOLD_RAW;
	localparam int MGL_SEARCH_CYC = 4; // Cycles spent walking the table on a miss
	localparam int MGL_CNT_W = 4;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [MGL_UPA_W-1:0] MGL_UPA_RESET = 24'h00_0000;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		MGL_ST_IDLE = 3'b000,
		MGL_ST_TRANSLATE = 3'b001,
		MGL_ST_HOLD = 3'b010,
		MGL_ST_SEARCH = 3'b011,
		MGL_ST_REGACC = 3'b100
	} mgl_state_t;

	// Mechanism enables, all cleared by reset
	typedef struct packed {
		logic translate;
		logic breakpoint;
		logic access_level;
	} mgl_cfg_t;

endpackage : mgl_pkg

// ==== verilog/mgl_xcache.sv ====
// Purpose: Small direct-mapped translation cache for upper address pages
// Assumes: One lookup and at most one fill per cycle
// Notes: Flush clears every valid bit in one cycle, except the entry filled in that cycle
module mgl_xcache
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Lookup
	input wire logic [mgl_pkg::MGL_UPA_W-1:0] lookup_page,
	output logic hit,
	output logic [mgl_pkg::MGL_UPA_W-1:0] hit_page,
	// Fill and flush
	input wire logic fill,
	input wire logic [mgl_pkg::MGL_UPA_W-1:0] fill_logical,
	input wire logic [mgl_pkg::MGL_UPA_W-1:0] fill_physical,
	input wire logic flush
);
	import mgl_pkg::*;

	logic [MGL_TAG_W-1:0] tag_mem [MGL_ENTRIES];
	logic [MGL_UPA_W-1:0] phys_mem [MGL_ENTRIES];
	logic [MGL_ENTRIES-1:0] valid;
	wire [MGL_IDX_W-1:0] look_idx = lookup_page[MGL_IDX_W-1:0];
	wire [MGL_IDX_W-1:0] fill_idx = fill_logical[MGL_IDX_W-1:0];

	// ------------------------------------------------------------------
	// Lookup
	// ------------------------------------------------------------------
	// Tag compare against the indexed entry
	assign hit = valid[look_idx] && (tag_mem[look_idx] == lookup_page[MGL_UPA_W-1:MGL_IDX_W]);
	assign hit_page = phys_mem[look_idx];

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	// Valid bits per entry; a fill in the flush cycle wins, it holds a fresh walk
	genvar e;
	generate
		for (e = 0; e < MGL_ENTRIES; e++)
		begin : g_entry
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					valid[e] <= 1'b0;
				else if (clk_en && fill && (fill_idx == MGL_IDX_W'(e)))
					valid[e] <= 1'b1;
				else if (clk_en && flush)
					valid[e] <= 1'b0;
			end

			// Data array needs no reset; valid guards it
			always_ff @(posedge clk)
			begin
				if (clk_en && fill && (fill_idx == MGL_IDX_W'(e)))
				begin
					tag_mem[e] <= fill_logical[MGL_UPA_W-1:MGL_IDX_W];
					phys_mem[e] <= fill_physical;
				end
			end
		end
	endgenerate

endmodule : mgl_xcache

// ==== verilog/mgl_glue.sv ====
// Purpose: Device-side bus sequencing of the paged memory management unit
// Assumes: Strobes active low and synchronous to clk
// Notes: Physical strobe and upper address are registered outputs
//
// What this block does
// - Drive upper address, hold after strobe negates
// - Never drive low shared address lines
// - Float upper address when bus granted away, after any cycle in progress ends
// - Reset disables translation, breakpoints, access levels
// - Sample timing input only translation, register access
module mgl_glue
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Logical bus side
	input wire logic logical_address_strobe_n,
	input wire logic [mgl_pkg::MGL_UPA_W-1:0] logical_page,
	input wire logic register_select,
	input wire logic nonnative_timing_input_n,
	// Table walk result and configuration
	input wire logic [mgl_pkg::MGL_UPA_W-1:0] walk_page,
	input wire logic cfg_write,
	input wire mgl_pkg::mgl_cfg_t cfg_data,
	// Physical bus arbitration
	input wire logic physical_bus_grant_n,
	// Physical bus side
	output logic physical_address_strobe_n,
	output logic [mgl_pkg::MGL_UPA_W-1:0] upper_physical_address,
	output logic upper_physical_address_oe,
	output logic low_order_shared_address_oe,
	output logic data_buffer_disable_n,
	// Status
	output logic nonnative_timing_seen,
	output logic register_cycle,
	output mgl_pkg::mgl_cfg_t mech_enable
);
	import mgl_pkg::*;

	mgl_state_t state;
	mgl_state_t next_state;
	logic [MGL_CNT_W-1:0] count;
	logic las_d;
	logic cfg_seen;

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	// Cycle start is the falling edge of the logical strobe
	wire las_fall = las_d && !logical_address_strobe_n;
	wire las_high = logical_address_strobe_n;
	wire granted = !physical_bus_grant_n;
	wire cache_hit;
	wire [MGL_UPA_W-1:0] cache_page;
	wire need_search = mech_enable.translate && !cache_hit;
	wire start_cycle = las_fall && !granted;
	wire search_done = (state == MGL_ST_SEARCH) && (count == '0);
	wire hold_done = (state == MGL_ST_HOLD) && (count == '0);
	// A fresh walk is not in the cache until the next edge, so use it directly
	wire [MGL_UPA_W-1:0] cached_page = search_done ? walk_page : cache_page;
	// Translation off means the page passes through unmapped
	wire [MGL_UPA_W-1:0] mapped_page = mech_enable.translate ? cached_page : logical_page;
	// Register access never searches, so it samples at its start even on a miss
	wire sample_start = start_cycle && (register_select || !need_search);

	mgl_xcache u_cache
	(
		.clk(clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.lookup_page(logical_page),
		.hit(cache_hit),
		.hit_page(cache_page),
		.fill(search_done),
		.fill_logical(logical_page),
		.fill_physical(walk_page),
		.flush(cfg_write && !cfg_data.translate)
	);

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	// Next state; a granted bus blocks any new cycle
	always_comb
	begin
		next_state = state;
		case (state)
			MGL_ST_IDLE:
				if (start_cycle && register_select)
					next_state = MGL_ST_REGACC;
				else if (start_cycle && need_search)
					next_state = MGL_ST_SEARCH;
				else if (start_cycle)
					next_state = MGL_ST_TRANSLATE;
			MGL_ST_SEARCH:
				if (search_done)
					next_state = MGL_ST_TRANSLATE;
			MGL_ST_TRANSLATE:
				if (las_high)
					next_state = MGL_ST_HOLD;
			MGL_ST_HOLD:
				if (hold_done)
					next_state = MGL_ST_IDLE;
			MGL_ST_REGACC:
				if (las_high)
					next_state = MGL_ST_IDLE;
			default:
				next_state = MGL_ST_IDLE;
		endcase
	end

	// State, counter and strobe history
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= MGL_ST_IDLE;
			count <= '0;
			las_d <= 1'b1;
		end
		else if (clk_en)
		begin
			state <= next_state;
			las_d <= logical_address_strobe_n;
			if (state == MGL_ST_IDLE && next_state == MGL_ST_SEARCH)
				count <= MGL_CNT_W'(MGL_SEARCH_CYC - 1);
			else if (state == MGL_ST_TRANSLATE && next_state == MGL_ST_HOLD)
				count <= MGL_CNT_W'(MGL_PA_HOLD_CYC - 1);
			else if (count != '0)
				count <= count - 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Physical bus outputs
	// ------------------------------------------------------------------
	// Address stays driven through the hold window, then floats
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			physical_address_strobe_n <= 1'b1;
			upper_physical_address <= MGL_UPA_RESET;
			upper_physical_address_oe <= 1'b0;
			low_order_shared_address_oe <= 1'b0;
			data_buffer_disable_n <= 1'b0; // Lets the config buffer drive in reset
		end
		else if (clk_en)
		begin
			data_buffer_disable_n <= 1'b1;
			low_order_shared_address_oe <= 1'b0;
			physical_address_strobe_n <= (next_state != MGL_ST_TRANSLATE);
			if (next_state == MGL_ST_TRANSLATE)
			begin
				upper_physical_address <= mapped_page;
				upper_physical_address_oe <= 1'b1;
			end
			else if (next_state == MGL_ST_IDLE)
				upper_physical_address_oe <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Timing input and mode enables
	// ------------------------------------------------------------------
	// Timing input read only at translation or register cycle start
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			nonnative_timing_seen <= 1'b0;
			register_cycle <= 1'b0;
			mech_enable <= '0;
			cfg_seen <= 1'b0;
		end
		else if (clk_en)
		begin
			register_cycle <= (next_state == MGL_ST_REGACC);
			if (state == MGL_ST_IDLE && sample_start)
				nonnative_timing_seen <= !nonnative_timing_input_n;
			else if (search_done)
				nonnative_timing_seen <= !nonnative_timing_input_n;
			if (cfg_write)
			begin
				mech_enable <= cfg_data;
				cfg_seen <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_pa_hold_after: assert property (@(posedge clk) disable iff (!resetn)
		(clk_en && $rose(physical_address_strobe_n)) |-> upper_physical_address_oe [*2])
		else $error("upper address not held after strobe negation");

	a_pa_valid_strobe: assert property (@(posedge clk) disable iff (!resetn)
		!physical_address_strobe_n |-> upper_physical_address_oe)
		else $error("physical strobe without upper address drive");

	a_low_never_driven: assert property (@(posedge clk) disable iff (!resetn)
		!low_order_shared_address_oe)
		else $error("low shared address driven");

	a_grant_floats_pa: assert property (@(posedge clk) disable iff (!resetn)
		(clk_en && granted && state == MGL_ST_IDLE) |=>
		(!upper_physical_address_oe && physical_address_strobe_n))
		else $error("upper address driven while bus granted");

	a_reset_mech_off: assert property (@(posedge clk) disable iff (!resetn)
		!cfg_seen |-> (mech_enable == '0))
		else $error("mechanism enabled without configuration after reset");

	a_search_ignores_timing: assert property (@(posedge clk) disable iff (!resetn)
		(state == MGL_ST_SEARCH && count != '0) |=> $stable(nonnative_timing_seen))
		else $error("timing input sampled during table search");

	a_regacc_samples_timing: assert property (@(posedge clk) disable iff (!resetn)
		(clk_en && state == MGL_ST_IDLE && start_cycle && register_select) |=>
		(nonnative_timing_seen == !$past(nonnative_timing_input_n) && register_cycle))
		else $error("timing input not sampled at register access");

endmodule : mgl_glue

// ==== sim/mgl_lmaster.sv ====
// Purpose: Logical bus master and table memory facing the glue block
// Assumes: Drives only just after falling edges of clk
// Notes: Released page lines show the inverse of the last page
module mgl_lmaster
#(
	parameter logic [23:0] WALK_XOR = 24'h5A_0F3C
)
(
	// Clock
	input wire logic clk,
	// Logical bus
	output logic logical_address_strobe_n,
	output logic [mgl_pkg::MGL_UPA_W-1:0] logical_page,
	output logic register_select,
	output logic nonnative_timing_input_n,
	// Table memory
	output logic [mgl_pkg::MGL_UPA_W-1:0] walk_page,
	// Board low address latch
	output logic [mgl_pkg::MGL_LOW_W-1:0] low_latched
);
	timeunit 1ns;
	timeprecision 1ns;
	import mgl_pkg::*;

	// Table walk answer; only looked at while the strobe is low
	assign walk_page = logical_page ^ WALK_XOR;

	logic [MGL_LOW_W-1:0] low_addr;

	// Board latch: see-through while the strobe is low, holds once it rises
	always @*
	begin
		if (!logical_address_strobe_n)
			low_latched = low_addr;
	end

	initial
	begin
		logical_address_strobe_n = 1'b1;
		logical_page = 24'h00_0000;
		register_select = 1'b0;
		nonnative_timing_input_n = 1'b1;
		low_addr = '0;
	end

	// One bus cycle; wig pulses the timing input during the search window
	task cycle(input logic [MGL_UPA_W-1:0] pg, input logic rs, input logic alt, input logic wig);
		@(negedge clk);
		nonnative_timing_input_n = !alt;
		logical_address_strobe_n = 1'b0;
		logical_page = pg;
		low_addr = pg[MGL_LOW_W-1:0];
		register_select = rs;
		@(negedge clk);
		if (wig)
			nonnative_timing_input_n = 1'b0;
		repeat (3) @(negedge clk);
		nonnative_timing_input_n = !alt;
		repeat (2) @(negedge clk);
		logical_address_strobe_n = 1'b1;
		// Released lines must not look like the last page
		logical_page = ~pg;
		low_addr = ~pg[MGL_LOW_W-1:0];
		register_select = 1'b0;
		repeat (5) @(negedge clk);
	endtask : cycle
endmodule : mgl_lmaster

// ==== sim/mgl_glue_bench.sv ====
// Purpose: Self-checking bench for the glue block
// Assumes: Pass-through page when translation is off
// Notes: Expected strobe results queue up; the monitor pops one per strobe
module mgl_glue_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import mgl_pkg::*;

	localparam logic [23:0] TABLE_XOR = 24'h3C_A5F0;
	logic clk = 1'b0;
	logic resetn, clk_en, grant_n, cfg_write, las_n, reg_sel, tim_n;
	logic pas_n, upa_oe, low_oe, dbd_n, seen, reg_cyc, prev_pas = 1'b1;
	logic [MGL_UPA_W-1:0] lpage, wpage, upa, pg, held;
	logic [MGL_LOW_W-1:0] lat_low, held_low;
	mgl_cfg_t cfg_data, mech;
	logic [MGL_UPA_W:0] notes[$];
	int bad_count = 0, cmp_count = 0, seed = 29, reg_hits = 0, since = 9;

	always #25 clk = ~clk;

	// Board view: config buffer drives only in reset; buffers float once granted and idle
	wire cfg_buf_en = !resetn && !dbd_n;
	wire buf_float = !grant_n && !upa_oe;

	mgl_glue uut (.clk(clk), .resetn(resetn), .clk_en(clk_en),
		.logical_address_strobe_n(las_n), .logical_page(lpage), .register_select(reg_sel),
		.nonnative_timing_input_n(tim_n), .walk_page(wpage), .cfg_write(cfg_write),
		.cfg_data(cfg_data), .physical_bus_grant_n(grant_n), .physical_address_strobe_n(pas_n),
		.upper_physical_address(upa), .upper_physical_address_oe(upa_oe),
		.low_order_shared_address_oe(low_oe), .data_buffer_disable_n(dbd_n),
		.nonnative_timing_seen(seen), .register_cycle(reg_cyc), .mech_enable(mech));
	mgl_lmaster #(.WALK_XOR(TABLE_XOR)) lm (.clk(clk), .logical_address_strobe_n(las_n),
		.logical_page(lpage), .register_select(reg_sel), .nonnative_timing_input_n(tim_n),
		.walk_page(wpage), .low_latched(lat_low));

	task check(input logic [MGL_UPA_W:0] got, input logic [MGL_UPA_W:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	task set_cfg(input mgl_cfg_t v);
		@(negedge clk);
		cfg_data = v;
		cfg_write = 1'b1;
		@(negedge clk);
		cfg_write = 1'b0;
		check({22'h00_0000, mech}, {22'h00_0000, v});
	endtask : set_cfg

	// Monitor: strobe results, address hold window, idle low lines
	always @(negedge clk)
	begin
		check({24'h00_0000, low_oe}, 25'h000_0000);
		if (prev_pas === 1'b1 && pas_n === 1'b0)
		begin
			// A strobe nobody asked for shows as a mismatch
			held = notes.size() ? notes[0][23:0] : ~upa;
			held_low = lpage[MGL_LOW_W-1:0];
			check({17'h0_0000, lat_low}, {17'h0_0000, held_low});
			if (notes.size() == 0)
				check(25'h000_0000, 25'h000_0001);
			else
				check({seen, upa}, notes.pop_front());
		end
		if (prev_pas === 1'b0 && pas_n === 1'b1)
			since = 0;
		else if (since < 9)
			since++;
		if (since < 2)
		begin
			check({upa_oe, upa}, {1'b1, held});
			check({17'h0_0000, lat_low}, {17'h0_0000, held_low});
		end
		if (since == 2)
			check({24'h00_0000, upa_oe}, 25'h000_0000);
		if (reg_cyc === 1'b1)
			reg_hits++;
		prev_pas = pas_n;
	end

	// Main sequence
	initial
	begin
		resetn = 1'b0;
		clk_en = 1'b1;
		grant_n = 1'b1;
		cfg_write = 1'b0;
		cfg_data = 3'h0;
		repeat (16) @(negedge clk);
		check({20'h0_0000, upa_oe, mech, dbd_n}, 25'h000_0000);
		check({24'h00_0000, cfg_buf_en}, 25'h000_0001);
		resetn = 1'b1;
		$display("test reset done");
		// Pass-through cycles, alternating the timing input
		for (int i = 0; i < 6; i++)
		begin
			pg = 24'($random(seed));
			notes.push_back({i[0], pg});
			lm.cycle(pg, 1'b0, i[0], 1'b0);
		end
		$display("test pass-through done");
		// Miss with timing noise during the search, then a hit
		set_cfg({1'b1, 2'($random(seed))});
		pg = 24'($random(seed));
		notes.push_back({1'b0, pg ^ TABLE_XOR});
		lm.cycle(pg, 1'b0, 1'b0, 1'b1);
		notes.push_back({1'b1, pg ^ TABLE_XOR});
		lm.cycle(pg, 1'b0, 1'b1, 1'b0);
		$display("test translation done");
		// Register access raises no physical strobe
		lm.cycle(pg, 1'b1, 1'b1, 1'b0);
		check({24'h00_0000, reg_hits > 0}, 25'h000_0001);
		$display("test register done");
		// Bus granted away: lines float and the request is dropped
		// Shared control lines are buffered on this board, so the logical side may run
		grant_n = 1'b0;
		lm.cycle(24'($random(seed)), 1'b0, 1'b0, 1'b0);
		check({24'h00_0000, upa_oe}, 25'h000_0000);
		check({24'h00_0000, buf_float}, 25'h000_0001);
		grant_n = 1'b1;
		$display("test grant done");
		// Clock enable low: a whole logical cycle passes unseen
		clk_en = 1'b0;
		lm.cycle(24'($random(seed)), 1'b0, 1'b0, 1'b0);
		clk_en = 1'b1;
		check({23'h00_0000, pas_n, upa_oe}, 25'h000_0002);
		$display("test freeze done");
		// Translation off flushes; page passes again
		set_cfg(3'b000);
		pg = 24'($random(seed));
		notes.push_back({1'b0, pg});
		lm.cycle(pg, 1'b0, 1'b0, 1'b0);
		$display("test flush done");
		// Reset in mid-run clears every mechanism
		set_cfg(3'b111);
		resetn = 1'b0;
		@(negedge clk);
		check({21'h00_0000, mech, dbd_n}, 25'h000_0000);
		check({24'h00_0000, cfg_buf_en}, 25'h000_0001);
		resetn = 1'b1;
		repeat (2) @(negedge clk);
		check({21'h00_0000, mech, dbd_n}, 25'h000_0001);
		check({24'h00_0000, cfg_buf_en}, 25'h000_0000);
		check(25'(notes.size()), 25'h000_0000);
		$display("test second reset done");
		conclude;
	end

	// Watchdog: the sequence needs well under 400 cycles
	initial
	begin
		#100_000;
		bad_count++;
		conclude;
	end
endmodule : mgl_glue_bench
